// >>> hw/psr_pkg.sv
// Constants and types shared by the processor supervisor reset sequencer.
package psr_pkg;

  // Clock period and the internal oscillator sample period.
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned SAMPLE_NS = 33000;
  localparam int unsigned TICK_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TICK_US = SAMPLE_NS / 1000;

  // Delay figures in microseconds.
  localparam int unsigned PWRUP_US = 25000;
  localparam int unsigned WDOG_US = 400000;
  localparam int unsigned RST_PULSE_US = 25000;
  localparam int unsigned NMI_PULSE_US = 200;
  localparam int unsigned DEBOUNCE_US = 1000;

  typedef logic [15:0] psr_cnt_t;

  // Hold counts get one extra tick because the first tick may arrive at once.
  localparam psr_cnt_t PWRUP_TK = psr_cnt_t'((PWRUP_US + TICK_US - 1) / TICK_US + 1);
  localparam psr_cnt_t RST_PULSE_TK = psr_cnt_t'((RST_PULSE_US + TICK_US - 1) / TICK_US + 1);
  localparam psr_cnt_t NMI_PULSE_TK = psr_cnt_t'((NMI_PULSE_US + TICK_US - 1) / TICK_US + 1);
  localparam psr_cnt_t DEBOUNCE_TK = psr_cnt_t'((DEBOUNCE_US + TICK_US - 1) / TICK_US);
  localparam psr_cnt_t WDOG_TK = psr_cnt_t'(WDOG_US / TICK_US);

  localparam logic [1:0] NMI_SAMPLES = 2'h3;
  localparam logic [1:0] LOW_ZERO = 2'h0;
  localparam psr_cnt_t CNT_ZERO = 16'h0000;
  localparam psr_cnt_t CNT_ONE = 16'h0001;
  localparam int unsigned IN_W = 6;

  // Raw pin inputs, all active high after the active-low ones are inverted.
  typedef struct packed {
    logic supply_low;
    logic sense_low;
    logic button_press;
    logic kick_low;
    logic mode_low_power;
    logic sleep_req;
  } psr_in_t;

  // Registered outputs.
  typedef struct packed {
    logic reset;
    logic power_fail;
    logic nmi;
    logic mem_block;
    logic low_power;
  } psr_out_t;

endpackage

// >>> hw/psr_top.sv
// Processor supervisor: reset, power-fail, early warning, memory gate and watchdog.
//
// Overview of operation
// R1: Mode select high picks low-power processor mode, low picks high-power mode.
// R2: Low-power mode never asserts reset merely because supply is out of tolerance.
// R3: Low-power mode pulses early-warning interrupt on a power failure.
// R4: Low-power mode still issues a power-on reset when supply returns.
// R5: High-power mode warns first, then holds reset for the whole supply loss.
// R6: Reset asserts while supply comparator reports supply below trip level; the code does so in high-power mode only.
// R7: After supply returns, reset stays asserted at least 25 ms.
// R8: During supply fault, power-fail asserts and memory enable is blocked.
// R9: Reset is driven on two complementary outputs showing the same state.
// R10: Power-fail is driven on two complementary outputs showing the same state.
// R11: Early-warning interrupt asserts when sense comparator reports supply below threshold.
// R12: Pushbutton is debounced and a valid press asserts reset.
// R13: Watchdog expiry without a kick asserts reset.
// R14: Processor kicks with falling edges; each restarts the watchdog period.
// R15: Sleep and wake control input puts the block into low-power state.
// R16: Watchdog period about 400 ms, under 600 ms, starts when reset ends.
// R17: Watchdog expiry holds reset active at least 25 ms.
// R18: Pushbutton reset lasts at least 25 ms after button release.
// R19: Interrupt needs three consecutive low samples 33 us apart; good sample restarts.
// R20: All delays count ticks of one internal oscillator with parameterised counts.
// R21: All comparator, button, kick and mode inputs are synchronised before use.
`timescale 1ns/100ps
module psr_top #(
  parameter int unsigned TICK_CYC = psr_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_i,
  input wire logic sense_low_i,
  input wire logic button_reset_n_i,
  input wire logic watchdog_kick_n_i,
  input wire logic processor_mode_select_i,
  input wire logic sleep_wake_ctl_n_i,
  input wire logic mem_enable_from_cpu_n_i,
  output logic reset_o,
  output logic reset_n_o,
  output logic power_fail_flag_o,
  output logic power_fail_flag_n_o,
  output logic nmi_n_o,
  output logic mem_enable_to_sram_n_o,
  output logic low_power_o
);

  // Saturating decrement on a tick.
  function automatic psr_pkg::psr_cnt_t dec_tk(input psr_pkg::psr_cnt_t cnt, input logic tick);
    dec_tk = (tick && cnt != psr_pkg::CNT_ZERO) ? cnt - psr_pkg::CNT_ONE : cnt;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  // Two flops per input; only the second stage feeds the logic below.
  psr_pkg::psr_in_t raw_in;
  psr_pkg::psr_in_t meta_q;
  psr_pkg::psr_in_t sync_q;
  logic kick_low_q;

  assign raw_in = '{supply_low: supply_low_i, sense_low: sense_low_i, button_press: ~button_reset_n_i,
                    kick_low: ~watchdog_kick_n_i, mode_low_power: processor_mode_select_i,
                    sleep_req: ~sleep_wake_ctl_n_i};

  for (genvar g = 0; g < psr_pkg::IN_W; g++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin // [R21]
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= raw_in[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  logic fault;
  logic cmos_mode;
  logic kick_fall;
  assign fault = sync_q.supply_low;
  assign cmos_mode = sync_q.mode_low_power; // [R1]
  assign kick_fall = sync_q.kick_low & ~kick_low_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      kick_low_q <= 1'b0;
    end else begin
      kick_low_q <= sync_q.kick_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick.
  // Every delay is a count of these ticks, so TICK_CYC alone scales them all.
  psr_pkg::psr_cnt_t tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == psr_pkg::psr_cnt_t'(TICK_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin // [R20]
    if (rst_i) begin
      tick_cnt_q <= psr_pkg::CNT_ZERO;
    end else if (tick) begin
      tick_cnt_q <= psr_pkg::CNT_ZERO;
    end else begin
      tick_cnt_q <= tick_cnt_q + psr_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pushbutton debounce.
  // Any bounce clears the count, so the press must stand for the whole debounce time.
  psr_pkg::psr_cnt_t deb_cnt_q;
  logic btn_active_q;
  logic btn_release;
  assign btn_release = btn_active_q & ~sync_q.button_press & ~fault;

  always_ff @(posedge clk_i or posedge rst_i) begin // [R12]
    if (rst_i) begin
      deb_cnt_q <= psr_pkg::CNT_ZERO;
      btn_active_q <= 1'b0;
    end else if (fault || !sync_q.button_press) begin
      deb_cnt_q <= psr_pkg::CNT_ZERO;
      btn_active_q <= 1'b0;
    end else if (tick && deb_cnt_q != psr_pkg::DEBOUNCE_TK) begin
      deb_cnt_q <= deb_cnt_q + psr_pkg::CNT_ONE;
    end else if (deb_cnt_q == psr_pkg::DEBOUNCE_TK) begin
      btn_active_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog.
  // The count is held at zero while reset, a fault or sleep is active.
  psr_pkg::psr_cnt_t wd_cnt_q;
  logic wd_run;
  logic wd_expire;
  assign wd_run = ~reset_o & ~fault & ~low_power_o; // [R16]
  assign wd_expire = wd_run & ~kick_fall & tick & (wd_cnt_q == psr_pkg::WDOG_TK - psr_pkg::CNT_ONE);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt_q <= psr_pkg::CNT_ZERO;
    end else if (!wd_run || kick_fall || wd_expire) begin // [R14]
      wd_cnt_q <= psr_pkg::CNT_ZERO;
    end else if (tick) begin
      wd_cnt_q <= wd_cnt_q + psr_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset hold timer and reset outputs.
  psr_pkg::psr_cnt_t hold_cnt_q;
  logic fault_q;
  logic reset_d;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_q <= 1'b1;
      hold_cnt_q <= psr_pkg::PWRUP_TK;
    end else begin
      fault_q <= fault;
      if (fault) begin
        hold_cnt_q <= psr_pkg::PWRUP_TK;
      end else if (fault_q) begin
        hold_cnt_q <= psr_pkg::PWRUP_TK; // [R4] [R7]
      end else if (wd_expire || btn_release) begin
        hold_cnt_q <= psr_pkg::RST_PULSE_TK; // [R13] [R17] [R18]
      end else begin
        hold_cnt_q <= dec_tk(hold_cnt_q, tick);
      end
    end
  end

  // In low-power mode the hold counter is still loaded during a fault but only
  // counts once the supply is back, so the fault itself causes no reset.
  assign reset_d = (fault & ~cmos_mode) | (~fault & hold_cnt_q != psr_pkg::CNT_ZERO) | btn_active_q; // [R2] [R5] [R6]

  always_ff @(posedge clk_i or posedge rst_i) begin // [R9]
    if (rst_i) begin
      reset_o <= 1'b1;
      reset_n_o <= 1'b0;
    end else begin
      reset_o <= reset_d;
      reset_n_o <= ~reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-fail, memory gate and sleep.
  // The chip enable path is not synchronised so that the gate adds one register of delay only.
  always_ff @(posedge clk_i or posedge rst_i) begin // [R8] [R10]
    if (rst_i) begin
      power_fail_flag_o <= 1'b1;
      power_fail_flag_n_o <= 1'b0;
      mem_enable_to_sram_n_o <= 1'b1;
    end else begin
      power_fail_flag_o <= fault;
      power_fail_flag_n_o <= ~fault;
      mem_enable_to_sram_n_o <= fault | mem_enable_from_cpu_n_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin // [R15]
    if (rst_i) begin
      low_power_o <= 1'b0;
    end else begin
      low_power_o <= sync_q.sleep_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Early-warning interrupt.
  // The sample count saturates so that a steady low level gives one pulse, not a train.
  logic [1:0] low_cnt_q;
  psr_pkg::psr_cnt_t nmi_cnt_q;
  logic nmi_start;
  assign nmi_start = tick & ~fault & sync_q.sense_low & (low_cnt_q == psr_pkg::NMI_SAMPLES - 2'h1);

  always_ff @(posedge clk_i or posedge rst_i) begin // [R19]
    if (rst_i) begin
      low_cnt_q <= psr_pkg::LOW_ZERO;
    end else if (fault || !sync_q.sense_low) begin
      low_cnt_q <= psr_pkg::LOW_ZERO;
    end else if (tick && low_cnt_q != psr_pkg::NMI_SAMPLES) begin
      low_cnt_q <= low_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin // [R3] [R11]
    if (rst_i) begin
      nmi_cnt_q <= psr_pkg::CNT_ZERO;
      nmi_n_o <= 1'b1;
    end else if (nmi_start) begin
      nmi_cnt_q <= psr_pkg::NMI_PULSE_TK;
      nmi_n_o <= 1'b0;
    end else if (!sync_q.sense_low || nmi_cnt_q == psr_pkg::CNT_ZERO) begin
      nmi_cnt_q <= psr_pkg::CNT_ZERO;
      nmi_n_o <= 1'b1;
    end else begin
      nmi_cnt_q <= dec_tk(nmi_cnt_q, tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_reset_pair_match: assert property (reset_o == ~reset_n_o) // [R9]
    else $error("reset outputs disagree");
  chk_fail_pair_match: assert property (power_fail_flag_o != power_fail_flag_n_o) // [R10]
    else $error("power-fail outputs disagree");
  chk_fault_sets_flag: assert property (fault |=> power_fail_flag_o && mem_enable_to_sram_n_o) // [R8]
    else $error("fault did not raise power-fail or block memory");
  chk_highpower_fault_reset: assert property (fault && !cmos_mode |=> reset_o) // [R5] [R6]
    else $error("high-power mode fault without reset");
  chk_lowpower_no_reset: assert property (fault && cmos_mode && !btn_active_q |=> !reset_o) // [R2]
    else $error("low-power mode fault caused reset");
  chk_powerup_hold: assert property ($fell(fault) |=> ##1 reset_o[*8]) // [R4] [R7]
    else $error("power-up reset not held");
  chk_nmi_three_low: assert property ($fell(nmi_n_o) |-> low_cnt_q == psr_pkg::NMI_SAMPLES) // [R19]
    else $error("interrupt without three low samples");
  chk_kick_restart: assert property (kick_fall && wd_run |=> wd_cnt_q == psr_pkg::CNT_ZERO) // [R14]
    else $error("kick did not restart watchdog");
  chk_wdog_pulse_load: assert property (wd_expire |=> hold_cnt_q == psr_pkg::RST_PULSE_TK ##1 reset_o) // [R13] [R17]
    else $error("watchdog expiry did not start reset pulse");
  chk_button_release_hold: assert property (btn_release |=> hold_cnt_q == psr_pkg::RST_PULSE_TK && reset_o) // [R18]
    else $error("button release did not start reset pulse");
  chk_mem_passthru: assert property (!fault |=> mem_enable_to_sram_n_o == $past(mem_enable_from_cpu_n_i)) // [R8]
    else $error("memory enable not passed through");
  chk_flag_clears: assert property (!fault |=> !power_fail_flag_o) // [R8] [R10]
    else $error("power-fail flag without fault");
  chk_powerup_load: assert property ($fell(fault) |-> hold_cnt_q == psr_pkg::PWRUP_TK) // [R4] [R7]
    else $error("power-up hold not loaded");
  chk_hold_count_down: assert property (tick && !fault && !fault_q && !wd_expire && !btn_release // [R7] [R20]
    && hold_cnt_q != psr_pkg::CNT_ZERO |=> hold_cnt_q == $past(hold_cnt_q) - psr_pkg::CNT_ONE)
    else $error("reset hold did not count down");
  chk_tick_wrap: assert property (tick |=> tick_cnt_q == psr_pkg::CNT_ZERO) // [R20]
    else $error("tick counter did not wrap");
  chk_sleep_follow: assert property (low_power_o == $past(sync_q.sleep_req)) // [R15]
    else $error("low-power output does not follow sleep request");
  chk_sleep_stops_wdog: assert property (low_power_o |=> wd_cnt_q == psr_pkg::CNT_ZERO) // [R15] [R16]
    else $error("watchdog ran during sleep");
  chk_reset_stops_wdog: assert property (reset_o |=> wd_cnt_q == psr_pkg::CNT_ZERO) // [R16]
    else $error("watchdog ran during reset");
  chk_wdog_bounded: assert property (wd_cnt_q < psr_pkg::WDOG_TK) // [R16]
    else $error("watchdog count beyond period");
  chk_debounce_gate: assert property ($rose(btn_active_q) |-> deb_cnt_q == psr_pkg::DEBOUNCE_TK) // [R12]
    else $error("press taken before debounce ended");
  chk_button_reset: assert property (btn_active_q |=> reset_o) // [R12]
    else $error("held button did not assert reset");
  chk_nmi_blocked_fault: assert property (fault && nmi_n_o |=> nmi_n_o) // [R19]
    else $error("interrupt started during supply fault");
  chk_nmi_ends_good: assert property (!sync_q.sense_low |=> nmi_n_o) // [R11]
    else $error("interrupt held after sense recovered");
  chk_nmi_pulse_len: assert property ($fell(nmi_n_o) |-> nmi_cnt_q == psr_pkg::NMI_PULSE_TK) // [R3]
    else $error("interrupt pulse length not loaded");

  cov_nmi_pulse: cover property ($fell(nmi_n_o) ##[1:1000] $rose(nmi_n_o));
  cov_wdog_expire: cover property (wd_expire);
  cov_button_reset: cover property (btn_release);
  cov_supply_return: cover property ($fell(fault));
  // A fault in low-power mode must be seen while reset is deasserted in the same cycle.
  cov_lowpower_fault: cover property (fault && cmos_mode && !reset_o);

endmodule

// >>> verif/psr_cpu_model.sv
// Processor model that kicks the watchdog and counts early-warning interrupts.
`timescale 1ns/100ps
module psr_cpu_model #(
  parameter int PERIOD = 400
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic nmi_n_i,
  input wire logic kick_en_i,
  output logic watchdog_kick_n_o,
  output int nmi_count_o
);
  int cnt = 0;
  initial watchdog_kick_n_o = 1'b1;
  initial nmi_count_o = 0;
  // A running processor strobes low for a few cycles once per period.
  always @(posedge clk_i) begin
    if (reset_n_i !== 1'b1 || !kick_en_i) begin
      cnt <= 0;
      watchdog_kick_n_o <= 1'b1;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      watchdog_kick_n_o <= (cnt < PERIOD - 8);
    end
  end
  always @(negedge nmi_n_i) nmi_count_o <= nmi_count_o + 1;
endmodule

// >>> verif/test_psr_top.sv
// Self-checking bench for the processor supervisor reset sequencer.
`timescale 1ns/100ps
module test_psr_top;
  localparam int TC = 2;
  localparam int HOLD = 25000 * TC / 33;
  localparam int NMIN = 200 * TC / 33;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sup = 1'b0, sen = 1'b0, btn_n = 1'b1, mode = 1'b0, slp_n = 1'b1, cpu_n = 1'b1, kick_en = 1'b1;
  logic kick_n, reset_o, reset_n_o, pf, pf_n, nmi_n, mem_n, low_power;
  int nmi_cnt, n, i, base;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  psr_top #(.TICK_CYC(TC)) uut (.clk_i(clk_i), .rst_i(rst_i), .supply_low_i(sup), .sense_low_i(sen),
    .button_reset_n_i(btn_n), .watchdog_kick_n_i(kick_n), .processor_mode_select_i(mode),
    .sleep_wake_ctl_n_i(slp_n), .mem_enable_from_cpu_n_i(cpu_n), .reset_o(reset_o), .reset_n_o(reset_n_o),
    .power_fail_flag_o(pf), .power_fail_flag_n_o(pf_n), .nmi_n_o(nmi_n), .mem_enable_to_sram_n_o(mem_n),
    .low_power_o(low_power));
  psr_cpu_model cpu (.clk_i(clk_i), .reset_n_i(reset_n_o), .nmi_n_i(nmi_n), .kick_en_i(kick_en),
    .watchdog_kick_n_o(kick_n), .nmi_count_o(nmi_cnt));
  //////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic exp_mem(input logic sup_low, input logic cpu_en_n);
    return sup_low | cpu_en_n;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic hold_len(output int c);
    c = 0;
    while (reset_o === 1'b1 && c < 50000) begin
      @(negedge clk_i);
      c++;
    end
  endtask
  task automatic wait_rise(input int mx, output int c);
    c = 0;
    while (reset_o !== 1'b1 && c < mx) begin
      @(negedge clk_i);
      c++;
    end
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (!rst_i) begin
      check(reset_n_o === ~reset_o, "reset outputs disagree");
      check(pf_n === ~pf, "power-fail outputs disagree");
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      $display("Error at %0t: run timed out", $time);
      results();
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(32'haa5e);
    cyc(12);
    check(reset_o === 1'b1 && pf === 1'b1 && nmi_n === 1'b1 && mem_n === 1'b1, "reset state");
    rst_i = 1'b0;
    hold_len(n);
    check(n >= HOLD, "power-up hold short");
    for (i = 0; i < 40; i++) begin
      cpu_n = 1'($urandom);
      cyc(1);
      check(mem_n === exp_mem(sup, cpu_n), "memory enable not passed");
    end
    for (i = 0; i < 2; i++) begin
      mode = i[0];
      cpu_n = 1'b0;
      cyc(5);
      sup = 1'b1;
      cyc(4);
      check(pf === 1'b1 && mem_n === exp_mem(sup, cpu_n), "fault outputs");
      check(reset_o === !i[0], "fault reset by mode");
      cyc(200);
      check(reset_o === !i[0], "reset during long fault");
      sup = 1'b0;
      cyc(4);
      check(pf === 1'b0 && mem_n === 1'b0 && reset_o === 1'b1, "supply return");
      hold_len(n);
      check(n >= HOLD - 4, "supply return hold short");
    end
    base = nmi_cnt;
    sen = 1'b1;
    cyc(2 * TC - 1);
    sen = 1'b0;
    cyc(10 * TC);
    check(nmi_cnt == base, "short dip raised interrupt");
    sen = 1'b1;
    n = 0;
    while (nmi_n !== 1'b0 && n < 6 * TC + 8) begin
      cyc(1);
      n++;
    end
    check(nmi_n === 1'b0 && n >= 2 * TC, "interrupt timing");
    n = 0;
    while (nmi_n === 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    check(n >= NMIN, "interrupt pulse short");
    cyc(30 * TC);
    check(nmi_cnt == base + 1, "interrupt repeated");
    sen = 1'b0;
    cyc(4);
    btn_n = 1'b0;
    cyc(25 * TC);
    check(reset_o === 1'b0, "press taken before debounce");
    cyc(12 * TC);
    check(reset_o === 1'b1, "press not taken");
    btn_n = 1'b1;
    cyc(3);
    hold_len(n);
    check(n >= HOLD - 3, "button hold short");
    slp_n = 1'b0;
    cyc(4);
    check(low_power === 1'b1, "sleep not entered");
    slp_n = 1'b1;
    cyc(4);
    check(low_power === 1'b0, "sleep not left");
    wait_rise(13000 * TC, n);
    check(reset_o === 1'b0, "kicked watchdog fired");
    kick_en = 1'b0;
    wait_rise(18200 * TC, n);
    check(reset_o === 1'b1 && n > 3030 * TC, "watchdog expiry");
    kick_en = 1'b1;
    hold_len(n);
    check(n >= HOLD - 1, "watchdog reset short");
    results();
  end
endmodule
